// >>> jdp_host.sv
// jdp_host: behavioural test host on the port pins
// assumes: 100 MHz clock; tck is gated and rests low between frames
`timescale 1ns/1ps
module jdp_host
	import jdp_pkg::*;
(
	// system
	input wire logic               clock,
	// pins
	output jdp_pkg::jdp_pins_t     pins,
	input wire jdp_pkg::jdp_tdo_t  tdo
);
	initial pins = 4'b0111;
	// one 80 ns tck period; tdo is taken a clock after the rise, where it stands
	task automatic step(input logic m, input logic d, output logic so, output logic soe);
		pins.tms <= m;
		pins.tdi <= d;
		repeat (4) @(posedge clock);
		pins.tck <= 1'b1;
		@(posedge clock);
		so = tdo.o;
		soe = tdo.oe;
		repeat (3) @(posedge clock);
		pins.tck <= 1'b0;
	endtask
	task automatic walk(input logic [7:0] ms, input int n);
		logic so, soe;
		for (int i = 0; i < n; i++)
			step(ms[i], 1'b1, so, soe);
	endtask
	task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got,
		output logic oe_all);
		logic so, soe;
		got = '0;
		oe_all = 1'b1;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], so, soe);
			got[i] = so;
			oe_all &= soe;
		end
	endtask
	// the host pulses test reset low for n clocks, on its own and not with the hardware reset
	task automatic hold_trst(input int n);
		pins.trst_n <= 1'b0;
		repeat (n) @(posedge clock);
		pins.trst_n <= 1'b1;
	endtask
endmodule

// >>> jdp_pkg.sv
// jdp_pkg: shared types and constants for the test port pin logic
// assumes: a single 100 MHz system clock samples every test pin
package jdp_pkg;

	// tap controller states, one-hot
	typedef enum logic [15:0] {
		JDP_RESET   = 16'h0001,
		JDP_IDLE    = 16'h0002,
		JDP_SEL_DR  = 16'h0004,
		JDP_CAP_DR  = 16'h0008,
		JDP_SH_DR   = 16'h0010,
		JDP_EX1_DR  = 16'h0020,
		JDP_PAU_DR  = 16'h0040,
		JDP_EX2_DR  = 16'h0080,
		JDP_UPD_DR  = 16'h0100,
		JDP_SEL_IR  = 16'h0200,
		JDP_CAP_IR  = 16'h0400,
		JDP_SH_IR   = 16'h0800,
		JDP_EX1_IR  = 16'h1000,
		JDP_PAU_IR  = 16'h2000,
		JDP_EX2_IR  = 16'h4000,
		JDP_UPD_IR  = 16'h8000
	} jdp_state_t;

	localparam int          JDP_IR_W       = 4;
	localparam int          JDP_DR_W       = 32;
	localparam logic [3:0]  JDP_IR_RESET   = 4'h1;
	localparam logic [3:0]  JDP_IR_BYPASS  = 4'hf;
	localparam logic [3:0]  JDP_IR_DBG     = 4'h8;
	localparam int          JDP_EVT_CYC    = 4;
	localparam logic [2:0]  JDP_EVT_CNT_W0 = 3'h0;

	// test pins seen by the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jdp_pins_t;

	// test data output pin as value and enable
	typedef struct packed {
		logic o;
		logic oe;
	} jdp_tdo_t;

endpackage

// >>> jdp_port.sv
// jdp_port: tap controller, instruction and data shifters, and the
// combined test-reset / debug-event pin of the debug test port
// assumes: tck is slow enough (80 ns) to be sampled by clock; debug events
// arrive as one-cycle pulses from logic on clock
// What this block does
// [RULE_01] all test logic but the debug-event pulse advances only on edges of the external, possibly gated, test clock
// [RULE_02] mode select is sampled at each test clock rise to step the controller
// [RULE_03] data input is sampled at each test clock rise into the shift path
// [RULE_04] data output is driven only in shift-ir and shift-dr, else released
// [RULE_05] data output changes only on test clock falling edges
// [RULE_06] a low on the combined pin, used as input, resets the controller
// [RULE_07] as programmed output, the combined pin pulses low on each debug event
// [RULE_08] while the combined pin is an output its reset input is ignored
// [RULE_09] host should assert test reset with hardware reset, unless debug needs otherwise; jdp_host keeps trst_n high through hardware reset
// [RULE_10] controller follows the sixteen-state sequence, entering reset on test reset
`timescale 1ns/1ps
module jdp_port
	import jdp_pkg::*;
#(
	parameter int EVT_CYC = JDP_EVT_CYC
) (
	// system
	input  wire logic               clock,
	input  wire logic               nrst,
	// test pins
	input  wire jdp_pkg::jdp_pins_t pins,
	output jdp_pkg::jdp_tdo_t       tdo,
	// combined pin as output
	output logic                    debug_event_out,
	output logic                    debug_event_oe,
	// core side
	input  wire logic               dbg_event,
	input  wire logic [31:0]        dbg_status,
	output logic [31:0]             dbg_cmd,
	output logic                    dbg_cmd_vld,
	output logic                    evt_mode
);
	import jdp_pkg::*;

	// ************************************************************
	// pin sampling
	// ************************************************************
	jdp_pins_t ps;

	jdp_sync #(
		.W    (4),
		.INIT (4'h5)
	) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   (pins),
		.dout  (ps)
	);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic                tck;
		jdp_state_t          st;
		logic [JDP_IR_W-1:0] ir;
		logic [JDP_IR_W-1:0] ir_sh;
		logic [JDP_DR_W-1:0] dr_sh;
		logic                byp;
		logic                sh_bit;
		logic                tdo_o;
		logic                tdo_oe;
		logic                evt_en;
		logic [2:0]          evt_cnt;
		logic                de_out;
		logic                de_oe;
		logic [31:0]         cmd;
		logic                cmd_vld;
	} jdp_reg_t;

	jdp_reg_t s_r;
	jdp_reg_t s_nxt;

	logic rise;
	logic fall;
	logic trst_act;

	always_comb begin
		rise     = ps.tck & ~s_r.tck; // [RULE_01]
		fall     = ~ps.tck & s_r.tck; // [RULE_01]
		trst_act = ~ps.trst_n & ~s_r.evt_en; // [RULE_06] [RULE_08]
		s_nxt         = s_r;
		s_nxt.tck     = ps.tck;
		s_nxt.cmd_vld = 1'b0;

		// ********************************************************
		// controller
		// ********************************************************
		if (trst_act) begin
			s_nxt.st  = JDP_RESET; // [RULE_06] [RULE_10]
			s_nxt.ir  = JDP_IR_RESET;
			s_nxt.evt_en = 1'b0;
		end else if (rise) begin
			unique case (s_r.st) // [RULE_02] [RULE_10]
				JDP_RESET:  s_nxt.st = ps.tms ? JDP_RESET  : JDP_IDLE;
				JDP_IDLE:   s_nxt.st = ps.tms ? JDP_SEL_DR : JDP_IDLE;
				JDP_SEL_DR: s_nxt.st = ps.tms ? JDP_SEL_IR : JDP_CAP_DR;
				JDP_CAP_DR: s_nxt.st = ps.tms ? JDP_EX1_DR : JDP_SH_DR;
				JDP_SH_DR:  s_nxt.st = ps.tms ? JDP_EX1_DR : JDP_SH_DR;
				JDP_EX1_DR: s_nxt.st = ps.tms ? JDP_UPD_DR : JDP_PAU_DR;
				JDP_PAU_DR: s_nxt.st = ps.tms ? JDP_EX2_DR : JDP_PAU_DR;
				JDP_EX2_DR: s_nxt.st = ps.tms ? JDP_UPD_DR : JDP_SH_DR;
				JDP_UPD_DR: s_nxt.st = ps.tms ? JDP_SEL_DR : JDP_IDLE;
				JDP_SEL_IR: s_nxt.st = ps.tms ? JDP_RESET  : JDP_CAP_IR;
				JDP_CAP_IR: s_nxt.st = ps.tms ? JDP_EX1_IR : JDP_SH_IR;
				JDP_SH_IR:  s_nxt.st = ps.tms ? JDP_EX1_IR : JDP_SH_IR;
				JDP_EX1_IR: s_nxt.st = ps.tms ? JDP_UPD_IR : JDP_PAU_IR;
				JDP_PAU_IR: s_nxt.st = ps.tms ? JDP_EX2_IR : JDP_PAU_IR;
				JDP_EX2_IR: s_nxt.st = ps.tms ? JDP_UPD_IR : JDP_SH_IR;
				JDP_UPD_IR: s_nxt.st = ps.tms ? JDP_SEL_DR : JDP_IDLE;
				default:    s_nxt.st = JDP_RESET;
			endcase

			// actions of the state being left, as in a real tap
			unique case (s_r.st)
				JDP_RESET: s_nxt.ir = JDP_IR_RESET;
				JDP_CAP_IR: s_nxt.ir_sh = JDP_IR_RESET;
				JDP_SH_IR: begin
					s_nxt.ir_sh = {ps.tdi, s_r.ir_sh[JDP_IR_W-1:1]}; // [RULE_03]
				end
				JDP_UPD_IR: s_nxt.ir = s_r.ir_sh;
				JDP_CAP_DR: begin
					s_nxt.dr_sh = dbg_status;
					s_nxt.byp   = 1'b0;
				end
				JDP_SH_DR: begin
					s_nxt.dr_sh = {ps.tdi, s_r.dr_sh[JDP_DR_W-1:1]}; // [RULE_03]
					s_nxt.byp   = ps.tdi; // [RULE_03]
				end
				JDP_UPD_DR: begin
					if (s_r.ir == JDP_IR_DBG) begin
						// bit 0 of a debug write selects the pin role
						s_nxt.evt_en  = s_r.dr_sh[0]; // [RULE_07]
						s_nxt.cmd     = s_r.dr_sh;
						s_nxt.cmd_vld = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// ********************************************************
		// data output, on test clock fall; enable also cleared on test reset
		// ********************************************************
		if (s_r.st == JDP_SH_IR)
			s_nxt.sh_bit = s_r.ir_sh[0];
		else if (s_r.ir == JDP_IR_DBG)
			s_nxt.sh_bit = s_r.dr_sh[0];
		else
			s_nxt.sh_bit = s_r.byp;
		if (trst_act) begin
			s_nxt.tdo_oe = 1'b0; // [RULE_04]
		end else if (fall) begin
			s_nxt.tdo_o  = s_r.sh_bit; // [RULE_05]
			s_nxt.tdo_oe = (s_r.st == JDP_SH_IR) || (s_r.st == JDP_SH_DR); // [RULE_04]
		end

		// ********************************************************
		// debug event pulse; stretched so a slow host can see it
		// ********************************************************
		s_nxt.de_oe = s_r.evt_en;
		if (!s_r.evt_en) begin
			s_nxt.evt_cnt = JDP_EVT_CNT_W0;
			s_nxt.de_out  = 1'b1;
		end else if (dbg_event) begin
			s_nxt.evt_cnt = 3'(EVT_CYC); // [RULE_07]
			s_nxt.de_out  = 1'b0; // [RULE_07]
		end else if (s_r.evt_cnt > 3'h1) begin
			s_nxt.evt_cnt = s_r.evt_cnt - 3'h1;
			s_nxt.de_out  = 1'b0;
		end else begin
			s_nxt.evt_cnt = JDP_EVT_CNT_W0;
			s_nxt.de_out  = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r         <= '0;
			s_r.st      <= JDP_RESET;
			s_r.ir      <= JDP_IR_RESET;
			s_r.de_out  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// outputs, all from flops
	// ************************************************************
	always_comb begin
		tdo.o           = s_r.tdo_o;
		tdo.oe          = s_r.tdo_oe;
		debug_event_out = s_r.de_out;
		debug_event_oe  = s_r.de_oe;
		dbg_cmd         = s_r.cmd;
		dbg_cmd_vld     = s_r.cmd_vld;
		evt_mode        = s_r.evt_en;
	end
endmodule

// >>> jdp_port_props.sv
// jdp_chk: timing checks on the test port pins
// assumes: bound into jdp_port, one clock domain
`timescale 1ns/1ps
module jdp_chk
	import jdp_pkg::*;
#(
	parameter int EVT_CYC = JDP_EVT_CYC
) (
	// system
	input wire logic               clock,
	input wire logic               nrst,
	// pins
	input wire jdp_pkg::jdp_pins_t pins,
	input wire jdp_pkg::jdp_tdo_t  tdo,
	input wire logic               debug_event_out,
	input wire logic               debug_event_oe,
	// core side
	input wire logic               dbg_event,
	input wire logic               evt_mode
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_oe_after_rst: assert property ($rose(nrst) |-> !tdo.oe)
		else $error("tdo driven after reset");
	// tck is sampled through two flops, so a fall is seen three clocks late
	a_tdo_on_fall: assert property ($changed(tdo.o) |-> !$past(pins.tck, 3))
		else $error("tdo changed while tck high");
	a_oe_on_fall: assert property ($rose(tdo.oe) |-> !$past(pins.tck, 3))
		else $error("tdo enabled while tck high");
	a_trst_resets: assert property ((!pins.trst_n && !evt_mode)[*5] |=> !tdo.oe)
		else $error("test reset left tdo driven");
	a_trst_ignored: assert property (evt_mode && !pins.trst_n |=> evt_mode)
		else $error("event role lost on test reset");
	a_evt_oe_on: assert property ($rose(evt_mode) |-> ##[0:1] debug_event_oe)
		else $error("event pin not enabled");
	a_evt_oe_off: assert property ($fell(evt_mode) |-> ##[0:1] !debug_event_oe)
		else $error("event pin still enabled");
	a_evt_pulse: assert property (debug_event_oe && dbg_event
		|=> !debug_event_out[*4] ##1 debug_event_out)
		else $error("event pulse shape wrong");
	a_evt_idle_hi: assert property (!debug_event_oe |-> debug_event_out)
		else $error("event pin low when unused");
endmodule
bind jdp_port jdp_chk #(.EVT_CYC(EVT_CYC)) u_chk (.clock(clock), .nrst(nrst), .pins(pins),
	.tdo(tdo), .debug_event_out(debug_event_out), .debug_event_oe(debug_event_oe),
	.dbg_event(dbg_event), .evt_mode(evt_mode));

// >>> jdp_sync.sv
// jdp_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to clock
`timescale 1ns/1ps
module jdp_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
) (
	// system
	input  wire logic         clock,
	input  wire logic         nrst,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_r <= INIT;
			dout   <= INIT;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// >>> test_jtag_debug_pin_interface.sv
// test bench for the debug test port pins
// assumes: jdp_host drives the pins, the bench drives the core side
`timescale 1ns/1ps
module test_jtag_debug_pin_interface;
	import jdp_pkg::*;
	logic        clock, nrst, dbg_event, debug_event_out, debug_event_oe, dbg_cmd_vld, evt_mode;
	logic [31:0] dbg_status, dbg_cmd, got;
	logic        oe, so;
	jdp_pins_t   pins;
	jdp_tdo_t    tdo;
	int          n_mismatch, checks_done, cnt, n_vld;
	jdp_port DUT (.clock(clock), .nrst(nrst), .pins(pins), .tdo(tdo),
		.debug_event_out(debug_event_out), .debug_event_oe(debug_event_oe),
		.dbg_event(dbg_event), .dbg_status(dbg_status), .dbg_cmd(dbg_cmd),
		.dbg_cmd_vld(dbg_cmd_vld), .evt_mode(evt_mode));
	jdp_host u_host (.clock(clock), .pins(pins), .tdo(tdo));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// count command strobes away from the edge that launches them
	always @(negedge clock) begin
		if (dbg_cmd_vld === 1'b1)
			n_vld++;
	end
	task automatic chk(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// from reset: select the dr path, ir still selects bypass
	task automatic t_bypass;
		u_host.walk(8'h1f, 5);
		u_host.walk(8'h02, 4);
		u_host.shift(32'hb6, 8, got, oe);
		chk(oe === 1'b1, "tdo not driven in shift");
		chk(got[7:1] === 7'h36, "bypass data");
		u_host.walk(8'h01, 2);
		u_host.step(1'b0, 1'b1, so, oe);
		chk(oe === 1'b0, "tdo driven in idle");
	endtask
	task automatic t_debug;
		u_host.walk(8'h03, 4);
		u_host.shift(32'h8, 4, got, oe);
		chk(got[3:0] === 4'h1, "ir capture");
		// exit-ir, update-ir, select-dr, capture-dr, then shift-dr
		u_host.walk(8'h03, 4);
		u_host.shift(32'h1234_5679, 32, got, oe);
		chk(got === dbg_status, "status capture");
		u_host.walk(8'h01, 2);
		chk(dbg_cmd === 32'h1234_5679 && evt_mode === 1'b1, "debug command");
		chk(n_vld == 1, "command strobe count");
		dbg_event <= 1'b1;
		@(posedge clock);
		dbg_event <= 1'b0;
		cnt = 0;
		repeat (10) begin
			@(negedge clock);
			cnt += int'(debug_event_out === 1'b0);
		end
		chk(cnt == JDP_EVT_CYC, "event pulse length");
		u_host.hold_trst(10);
		chk(evt_mode === 1'b1, "test reset not ignored");
	endtask
	task automatic t_trst;
		u_host.walk(8'h01, 3);
		u_host.shift(32'h0, 32, got, oe);
		u_host.walk(8'h01, 5);
		chk(evt_mode === 1'b0, "event role kept");
		u_host.hold_trst(10);
		chk(tdo.oe === 1'b0, "tdo driven after test reset");
		u_host.walk(8'h02, 4);
		u_host.shift(32'hb6, 8, got, oe);
		chk(got[7:1] === 7'h36, "ir not reset");
	endtask
	initial begin
		nrst = 1'b0;
		dbg_event = 1'b0;
		dbg_status = 32'ha5c3_0f96;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		chk(tdo.oe === 1'b0 && debug_event_out === 1'b1, "reset levels");
		t_bypass();
		t_debug();
		t_trst();
		tally_and_finish();
	end
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
